// File: hw/timer_pkg.sv
package timer_pkg;

  // register bus
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // register addresses
  localparam logic [15:0] MODE_ADDR  = 16'hFFB0;
  localparam logic [15:0] COUNT_ADDR = 16'hFFB1;
  localparam logic [15:0] STAT_ADDR  = 16'hFFB2;
  localparam logic [15:0] MASK_ADDR  = 16'hFFB3;

  // reset values
  localparam logic [7:0] MODE_RESET  = 8'h10;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET  = 8'h00;

  // mode register fields
  localparam int unsigned OSEL_LSB  = 5;
  localparam int unsigned FIXED_BIT = 4;
  localparam int unsigned TB_BIT    = 3;
  localparam int unsigned PSEL_LSB  = 0;

  // status and mask fields
  localparam int unsigned OVF_BIT = 0;

  // operating state codes
  localparam logic [1:0] OP_ACTIVE    = 2'h0;
  localparam logic [1:0] OP_SLEEP     = 2'h1;
  localparam logic [1:0] OP_SUBACTIVE = 2'h2;
  localparam logic [1:0] OP_WATCH     = 2'h3;

  // prescaler widths
  localparam int unsigned PSC_S_W = 13;
  localparam int unsigned PSC_W_W = 7;

  // tick taps as log2 of divisor; output taps as log2 of divisor minus one
  localparam int unsigned IV_SHIFT [8] = '{13, 12, 11, 9, 8, 7, 5, 3};
  localparam int unsigned TB_SHIFT [4] = '{7, 6, 5, 2};
  localparam int unsigned OUT_BIT  [4] = '{4, 3, 2, 1};

  // sub-clock loss detection
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SUB_LOSS_NS   = 100000;
  localparam int unsigned SUB_LOSS_CYC  = SUB_LOSS_NS / CLK_PERIOD_NS;

endpackage

// File: hw/pin_sync3.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // pin side
  input  wire logic pin,
  // filtered side
  output logic      level,
  output logic      rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
  } sync_t;

  sync_t st_q;
  sync_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.s1   = pin;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.rise = 1'b0;
    // change taken only once stages two and three agree
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl  = st_q.s3;
      st_d.rise = st_q.s3 & ~st_q.lvl;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lvl;
  assign rise  = st_q.rise;

endmodule

`default_nettype wire

// File: hw/div_counter.sv
`timescale 1ns/1ps
`default_nettype none

module div_counter #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // advance
  input  wire logic             step,
  // free-running count
  output logic [WIDTH-1:0]      count
);

  // refused at elaboration: wider counters outgrow the tap masks
  if (WIDTH < 2 || WIDTH > 16) begin : g_width_chk
    $error("div_counter: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } div_t;

  div_t st_q;
  div_t st_d;

  always_comb begin
    st_d = st_q;
    if (step) begin
      st_d.cnt = st_q.cnt + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count = st_q.cnt;

endmodule

`default_nettype wire

// File: hw/interval_timebase_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - 8-bit counter serving as interval timer and as clock time base.
// - interval mode counts system clock divided by 8192,4096,2048,512,256,128,32,8.
// - time-base overflow periods 1 s, 0.5 s, 0.25 s, 31.25 ms from sub-clock.
// - time-base counting works only while the 32.768 kHz sub-clock is present.
// - every counter overflow raises the interrupt request when the mask bit is set, in either mode.
// - mode register resets to 0x10; bit 4 always reads one.
// - mode bits 7..5 pick one of eight divided clocks for the output pin.
// - sub-clock output choices are 32.768 kHz divided by 32, 16, 8, 4.
// - system-clock output choices run only in active or sleep state.
// - sub-clock output choices run in active, sleep and subactive states.
module interval_timebase_timer
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // register port
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // sub-clock pin and power state
  input  wire logic        sub_clk_pin,
  input  wire logic [1:0]  op_state,
  // outputs
  output logic             divided_clock_out_pin,
  output logic             irq
);

  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  count;
    logic        ovf_st;
    logic        ovf_mask;
    logic [11:0] loss_cnt;
    logic        sub_ok;
    logic [7:0]  rdata;
    logic        irq;
    logic        clk_out;
  } state_t;

  localparam logic [11:0] LOSS_LIMIT = 12'(SUB_LOSS_CYC);

  state_t st_q;
  state_t st_d;

  // prescaler outputs
  logic [PSC_S_W-1:0] psc_s;
  logic [PSC_W_W-1:0] psc_w;
  logic               sub_level;
  logic               sub_rise;

  // derived controls
  logic [2:0] osel;
  logic [2:0] psel;
  logic       mode_tb;
  logic       tick;
  logic       ovf_ev;
  logic       sys_out_ok;
  logic       sub_out_ok;
  logic       out_bit;

  // register access decode
  logic wr_mode;
  logic wr_stat;
  logic wr_mask;

  function automatic logic low_ones(input logic [12:0] v, input int unsigned k);
    logic [12:0] m;
    m        = 13'((32'h1 << k) - 32'h1);
    low_ones = ((v & m) == m);
  endfunction

  pin_sync3 u_sub_sync (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (sub_clk_pin),
    .level (sub_level),
    .rise  (sub_rise)
  );

  // system prescaler runs every cycle
  div_counter #(
    .WIDTH (PSC_S_W)
  ) u_psc_s (
    .clk   (clk),
    .nrst  (nrst),
    .step  (1'b1),
    .count (psc_s)
  );

  // sub-clock prescaler advances on each sub-clock rise
  div_counter #(
    .WIDTH (PSC_W_W)
  ) u_psc_w (
    .clk   (clk),
    .nrst  (nrst),
    .step  (sub_rise),
    .count (psc_w)
  );

  assign osel    = st_q.mode[OSEL_LSB +: 3];
  assign psel    = st_q.mode[PSEL_LSB +: 3];
  assign mode_tb = st_q.mode[TB_BIT];

  assign wr_mode = wr && (addr == MODE_ADDR);
  assign wr_stat = wr && (addr == STAT_ADDR);
  assign wr_mask = wr && (addr == MASK_ADDR);

  // counter clock source
  // all-ones taps: every divisor must stay a power of two
  always_comb begin
    if (mode_tb) begin
      tick = st_q.sub_ok && sub_rise && low_ones({6'h0, psc_w}, TB_SHIFT[psel[1:0]]);
    end else begin
      tick = low_ones(psc_s, IV_SHIFT[psel]);
    end
  end

  assign ovf_ev = tick && (st_q.count == 8'hFF);

  // output clock gating by power state
  assign sys_out_ok = (op_state == OP_ACTIVE) || (op_state == OP_SLEEP);
  assign sub_out_ok = sys_out_ok || (op_state == OP_SUBACTIVE);

  always_comb begin
    if (osel[2]) begin
      out_bit = sub_out_ok && psc_w[OUT_BIT[osel[1:0]]];
    end else begin
      out_bit = sys_out_ok && psc_s[OUT_BIT[osel[1:0]]];
    end
  end

  always_comb begin
    st_d       = st_q;
    st_d.rdata = 8'h00;

    // writable fields; bit 4 is tied high
    if (wr_mode) begin
      st_d.mode            = wdata;
      st_d.mode[FIXED_BIT] = 1'b1;
    end

    // count up, wrap naturally at the top
    if (tick) begin
      st_d.count = st_q.count + 8'h01;
    end

    if (wr_mask) begin
      st_d.ovf_mask = wdata[OVF_BIT];
    end

    // overflow flag: set beats a same-cycle write-one clear
    if (wr_stat && wdata[OVF_BIT]) begin
      st_d.ovf_st = 1'b0;
    end
    if (ovf_ev) begin
      st_d.ovf_st = 1'b1;
    end

    // sub-clock presence: lost if no rise within the loss window
    // a stalled sub-clock freezes the time base rather than letting it drift
    if (sub_rise) begin
      st_d.loss_cnt = 12'h000;
      st_d.sub_ok   = 1'b1;
    end else if (st_q.loss_cnt != LOSS_LIMIT) begin
      st_d.loss_cnt = st_q.loss_cnt + 12'h001;
    end else begin
      st_d.sub_ok = 1'b0;
    end

    // read data stand one cycle only
    if (rd) begin
      unique case (addr)
        MODE_ADDR:  st_d.rdata = st_q.mode;
        COUNT_ADDR: st_d.rdata = st_q.count;
        STAT_ADDR:  st_d.rdata = {7'h00, st_q.ovf_st};
        MASK_ADDR:  st_d.rdata = {7'h00, st_q.ovf_mask};
        default:    st_d.rdata = 8'h00;
      endcase
    end

    st_d.irq     = st_d.ovf_st && st_d.ovf_mask;
    st_d.clk_out = out_bit;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q.mode     <= MODE_RESET;
      st_q.count    <= COUNT_RESET;
      st_q.ovf_st   <= STAT_RESET[OVF_BIT];
      st_q.ovf_mask <= MASK_RESET[OVF_BIT];
      st_q.loss_cnt <= 12'h000;
      st_q.sub_ok   <= 1'b0;
      st_q.rdata    <= 8'h00;
      st_q.irq      <= 1'b0;
      st_q.clk_out  <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata                 = st_q.rdata;
  assign irq                   = st_q.irq;
  assign divided_clock_out_pin = st_q.clk_out;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  count_wrap_a: assert property (ovf_ev |=> st_q.count == 8'h00)
    else $error("counter did not wrap to zero");

  count_step_a: assert property (tick && !ovf_ev |=> st_q.count == $past(st_q.count) + 8'h01)
    else $error("counter did not step by one");

  count_hold_a: assert property (!tick |=> $stable(st_q.count))
    else $error("counter moved without a tick");

  div8_period_a: assert property (
    (!mode_tb && psel == 3'h7 && tick) |=>
    (!tick || mode_tb || psel != 3'h7)[*7] ##1
    (tick || mode_tb || psel != 3'h7))
    else $error("divide-by-8 tick spacing wrong");

  tb_gate_a: assert property (mode_tb && !st_q.sub_ok |-> !tick)
    else $error("time-base tick without sub-clock");

  tb_source_a: assert property (mode_tb && tick |-> sub_rise)
    else $error("time-base tick not on a sub-clock rise");

  ovf_flag_a: assert property (ovf_ev |=> st_q.ovf_st ##0 (irq == st_q.ovf_mask))
    else $error("overflow did not raise the request");

  fixed_bit_a: assert property (rd && addr == MODE_ADDR |=> rdata[FIXED_BIT])
    else $error("mode bit 4 read as zero");

  out_select_a: assert property (
    wr_mode |=> osel == $past(wdata[OSEL_LSB +: 3]))
    else $error("output select not updated");

  sys_out_off_a: assert property (!osel[2] && !sys_out_ok |=> !divided_clock_out_pin)
    else $error("system clock output outside active or sleep");

  sub_out_on_a: assert property (
    osel[2] && op_state == OP_SUBACTIVE |=> divided_clock_out_pin == $past(psc_w[4 - osel[1:0]]))
    else $error("sub-clock output missing in subactive");

  sub_tap_a: assert property (
    osel == 3'h7 && sub_out_ok |=> divided_clock_out_pin == $past(psc_w[1]))
    else $error("sub-clock divide-by-4 output wrong");

  interval_align_a: assert property (
    !mode_tb && tick |-> psc_s[2:0] == 3'h7)
    else $error("interval tick off the prescaler tap");

  count_read_a: assert property (
    rd && addr == COUNT_ADDR |=> rdata == $past(st_q.count))
    else $error("count read returned a stale value");

  count_ro_a: assert property (
    wr && addr == COUNT_ADDR && !tick |=> $stable(st_q.count))
    else $error("write reached the read-only counter");

  stat_clear_a: assert property (
    wr_stat && wdata[OVF_BIT] && !ovf_ev |=> !st_q.ovf_st)
    else $error("overflow flag not cleared by write-one");

  set_wins_a: assert property (
    ovf_ev && wr_stat && wdata[OVF_BIT] |=> st_q.ovf_st)
    else $error("clear beat a same-cycle overflow");

  irq_mask_a: assert property (
    !st_q.ovf_mask |-> !irq)
    else $error("masked overflow raised the request");

  sys_out_on_a: assert property (
    !osel[2] && sys_out_ok |=> divided_clock_out_pin == $past(psc_s[4 - osel[1:0]]))
    else $error("system clock output wrong in active or sleep");

  watch_off_a: assert property (
    op_state == OP_WATCH |=> !divided_clock_out_pin)
    else $error("clock output running in watch state");

  sub_lost_a: assert property (
    !sub_rise && st_q.loss_cnt == LOSS_LIMIT |=> !st_q.sub_ok)
    else $error("sub-clock loss not detected");

  sub_back_a: assert property (
    sub_rise |=> st_q.sub_ok)
    else $error("sub-clock rise did not restore the time base");

  ovf_seen_c:  cover property (ovf_ev);
  tb_tick_c:   cover property (mode_tb && tick);
  irq_rise_c:  cover property ($rose(irq));
  clear_race_c: cover property (ovf_ev && wr_stat && wdata[OVF_BIT]);
  sub_loss_c:   cover property ($fell(st_q.sub_ok));

endmodule

`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import timer_pkg::*;
  logic        clk         = 1'b0;
  logic        nrst        = 1'b0;
  logic        wr          = 1'b0;
  logic        rd          = 1'b0;
  logic        sub_clk_pin = 1'b0;
  logic        sub_run     = 1'b0;
  logic [15:0] addr        = 16'h0000;
  logic [7:0]  wdata       = 8'h00;
  logic [1:0]  op_state    = 2'h0;
  logic [7:0]  rdata;
  logic [7:0]  v0;
  logic [7:0]  v1;
  logic        divided_clock_out_pin;
  logic        irq;
  logic [31:0] seed        = 32'h1BAB89A4;
  int          mismatches  = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          sub_cnt     = 0;
  int          r;
  int          dv [8]      = '{8192, 4096, 2048, 512, 256, 128, 32, 8};

  interval_timebase_timer u_interval_timebase_timer (
    .clk                   (clk),
    .nrst                  (nrst),
    .addr                  (addr),
    .wdata                 (wdata),
    .wr                    (wr),
    .rd                    (rd),
    .rdata                 (rdata),
    .sub_clk_pin           (sub_clk_pin),
    .op_state              (op_state),
    .divided_clock_out_pin (divided_clock_out_pin),
    .irq                   (irq)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  // sub-clock: 610 system cycles, close to 32.768 kHz; halts when stopped
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (sub_run) begin
      sub_cnt <= (sub_cnt == 304) ? 0 : sub_cnt + 1;
      if (sub_cnt == 304) sub_clk_pin <= ~sub_clk_pin;
    end
    if (cycles == 80000) begin
      mismatches++;
      print_verdict();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // bit 4 is forced to one on every mode write and always reads one
  function automatic logic [7:0] mode_rb(input logic [7:0] d);
    return d | 8'h10;
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // two count reads exactly n cycles apart
  task automatic gap(input int n);
    rd_reg(COUNT_ADDR, v0);
    repeat (n - 2) @(posedge clk);
    rd_reg(COUNT_ADDR, v1);
  endtask

  task automatic rises(input int n);
    logic p;
    // first sample only once the new setting has reached the pin
    @(posedge clk);
    #1;
    p = divided_clock_out_pin;
    r = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (divided_clock_out_pin === 1'b1 && p === 1'b0) r++;
      p = divided_clock_out_pin;
    end
    // return on an edge so the next drive lands on it
    @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    nrst    <= 1'b1;
    sub_run <= 1'b1;
    rd_reg(MODE_ADDR, v0);
    check("mode reset", v0, MODE_RESET);
    rd_reg(COUNT_ADDR, v0);
    check("count reset", v0, COUNT_RESET);
    rd_reg(STAT_ADDR, v0);
    check("status reset", v0, STAT_RESET);
    rd_reg(MASK_ADDR, v0);
    check("mask reset", v0, MASK_RESET);
    rd_reg(16'hFFB4, v0);
    check("unmapped", v0, 8'h00);
    check("irq reset", {7'h00, irq}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      wr_reg(MODE_ADDR, seed[7:0]);
      rd_reg(MODE_ADDR, v0);
      check("mode readback", v0, mode_rb(seed[7:0]));
    end
    $display("test registers done");
    for (int p = 0; p < 8; p++) begin
      wr_reg(MODE_ADDR, p[7:0]);
      gap(dv[p]);
      check("interval step", v1 - v0, 8'h01);
    end
    $display("test prescaler done");
    wr_reg(MODE_ADDR, 8'h07);
    wr_reg(STAT_ADDR, 8'h01);
    gap(2048);
    check("wrap", v1, v0);
    rd_reg(STAT_ADDR, v0);
    check("overflow flag", v0, 8'h01);
    check("irq masked", {7'h00, irq}, 8'h00);
    wr_reg(MASK_ADDR, 8'h01);
    repeat (2) @(negedge clk);
    check("irq unmasked", {7'h00, irq}, 8'h01);
    wr_reg(STAT_ADDR, 8'h01);
    repeat (2) @(negedge clk);
    check("irq cleared", {7'h00, irq}, 8'h00);
    $display("test overflow done");
    wr_reg(MODE_ADDR, 8'h0B);
    gap(4880);
    check("time base step", v1 - v0, 8'h02);
    // 0.25 s choice: one tick per 32 sub-clock rises
    wr_reg(MODE_ADDR, 8'h0A);
    gap(19520);
    check("time base quarter", v1 - v0, 8'h01);
    $display("test time base done");
    // output select: sys/4 and sys/32, then state gating
    wr_reg(MODE_ADDR, 8'h60);
    rises(64);
    check("sys/4 rises", r[7:0], 8'h10);
    wr_reg(MODE_ADDR, 8'h00);
    rises(64);
    check("sys/32 rises", r[7:0], 8'h02);
    wr_reg(MODE_ADDR, 8'h60);
    op_state <= OP_SLEEP;
    rises(64);
    check("sys in sleep", r[7:0], 8'h10);
    op_state <= OP_SUBACTIVE;
    rises(64);
    check("sys in subactive", r[7:0], 8'h00);
    wr_reg(MODE_ADDR, 8'hE0);
    rises(4880);
    check("sub/4 rises", r[7:0], 8'h02);
    wr_reg(MODE_ADDR, 8'hC0);
    rises(4880);
    check("sub/8 rises", r[7:0], 8'h01);
    wr_reg(MODE_ADDR, 8'hE0);
    op_state <= OP_WATCH;
    rises(4880);
    check("sub in watch", r[7:0], 8'h00);
    $display("test clock output done");
    // stopped sub-clock must freeze the time base
    op_state <= OP_ACTIVE;
    wr_reg(MODE_ADDR, 8'h0B);
    sub_run <= 1'b0;
    repeat (2500) @(posedge clk);
    gap(4880);
    check("no sub-clock", v1 - v0, 8'h00);
    $display("test sub-clock loss done");
    print_verdict();
  end
endmodule

`default_nettype wire
